// >>> design/bbse_map.svh
`ifndef BBSE_MAP_SVH
`define BBSE_MAP_SVH
// opcode fields
`define BBSE_REL_OP_HI       15
`define BBSE_REL_OP_LO       11
`define BBSE_REL_OPCODE      5'h1a
`define BBSE_SET_OP_HI       15
`define BBSE_SET_OP_LO       12
`define BBSE_SET_OPCODE      4'h8
`define BBSE_BIT_HI          11
`define BBSE_BIT_LO          9
`define BBSE_ACC_BIT         8
`define BBSE_FADDR_HI        7
`define BBSE_FADDR_LO        0
`define BBSE_OFS_HI          10
// indexed literal offset limit on the file address
`define BBSE_IDX_LIMIT       8'h5f
// instruction cycle lengths
`define BBSE_REL_CYCLES      2
`define BBSE_SET_CYCLES      1
// reset values
`define BBSE_CNT_RST         21'h00000
`define BBSE_Q_RST           2'h0
`endif

// >>> design/bbse_pkg.sv
package bbse_pkg;
    // quarter phases of one instruction cycle
    typedef enum logic [1:0] {
        BBSE_Q1,
        BBSE_Q2,
        BBSE_Q3,
        BBSE_Q4
    } bbse_q_e;
    // instruction class seen by the decoder
    typedef enum logic [1:0] {
        BBSE_OP_NONE,
        BBSE_OP_BRANCH,
        BBSE_OP_BITSET
    } bbse_op_e;
endpackage : bbse_pkg

// >>> design/bbse_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "bbse_map.svh"
module bbse_decode
    import bbse_pkg::*;
(
    input  wire logic [15:0]    instr_i,    // fetched instruction word
    output bbse_pkg::bbse_op_e  op_o,       // decoded class
    output logic signed [10:0]  offset_o,   // signed word offset
    output logic [2:0]          bit_o,      // bit index
    output logic                acc_o,      // bank-access flag
    output logic [7:0]          faddr_o     // file address
);
    // opcode match for the two supported instructions
    always_comb begin
        if (instr_i[`BBSE_REL_OP_HI:`BBSE_REL_OP_LO] == `BBSE_REL_OPCODE) begin
            op_o = BBSE_OP_BRANCH;
        end else if (instr_i[`BBSE_SET_OP_HI:`BBSE_SET_OP_LO] == `BBSE_SET_OPCODE) begin
            op_o = BBSE_OP_BITSET;
        end else begin
            op_o = BBSE_OP_NONE;
        end
    end
    // operand fields
    assign offset_o = $signed(instr_i[`BBSE_OFS_HI:0]);
    assign bit_o    = instr_i[`BBSE_BIT_HI:`BBSE_BIT_LO];
    assign acc_o    = instr_i[`BBSE_ACC_BIT];
    assign faddr_o  = instr_i[`BBSE_FADDR_HI:`BBSE_FADDR_LO];
endmodule // bbse_decode
`default_nettype wire

// >>> design/bbse_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "bbse_map.svh"
// Function
// - branch opcode 11010 with 11-bit offset
// - target is incremented counter plus twice offset
// - branch takes two cycles, flags untouched
// - branch writes counter in Q4, then idles
// - bit-set opcode 1000, bit, access, address
// - set chosen bit, keep others and flags
// - access flag picks access or selected bank
// - indexed mode when a=0, extended, f<=95
// - bit-set is one cycle, write in Q4
module bbse_core
    import bbse_pkg::*;
#(
    parameter int CNT_W = 21  // program counter width
) (
    input  wire logic              clk_i,           // core clock, one quarter per edge
    input  wire logic              rst_n_i,         // asynchronous reset, active low
    input  wire logic [15:0]       instr_i,         // prefetched instruction word
    input  wire logic              instr_valid_i,   // instruction word present
    input  wire logic [3:0]        bank_select_register_i, // selected data bank
    input  wire logic              ext_set_en_i,    // extended instruction set enabled
    input  wire logic [11:0]       index_ptr_i,     // index pointer for literal offset
    input  wire logic [7:0]        file_rdata_i,    // register file read data
    output logic [CNT_W-1:0]       program_counter_o, // program counter
    output logic [11:0]            file_addr_o,     // register file address
    output logic                   file_rd_o,       // register file read strobe (Q2)
    output logic                   file_we_o,       // register file write strobe (Q4)
    output logic [7:0]             file_wdata_o,    // register file write data
    output logic                   flush_o,         // prefetch discarded (branch)
    output logic                   idle_o,          // second branch cycle, no operation
    output bbse_pkg::bbse_q_e      q_o              // current quarter
);
    // elaboration check: the counter must carry the doubled offset and be at most 32 bits wide
    if (CNT_W < 12 || CNT_W > 32) begin : g_bad_width
        $error("bbse_core: CNT_W out of range");
    end

    bbse_q_e            q;          // quarter phase
    logic               idle;       // no-operation cycle pending/active
    bbse_op_e           op;         // decoded class from the decoder
    bbse_op_e           cur_op;     // class latched at Q1
    logic signed [10:0] offset;     // decoded offset
    logic [2:0]         bit_idx;    // decoded bit index
    logic               acc;        // decoded access flag
    logic [7:0]         faddr;      // decoded file address
    logic signed [10:0] lit;        // literal captured in Q2
    logic signed [10:0] cur_ofs;    // offset latched with the word in Q1
    logic [CNT_W-1:0]   target;     // branch target computed in Q3
    logic [7:0]         mod_data;   // modified byte from Q3
    logic [2:0]         cur_bit;    // latched bit index
    logic [11:0]        ea;         // effective data address
    logic [11:0]        next_ea;    // address as computed from fields
    logic               indexed;    // indexed literal offset applies

    bbse_decode i_bbse_decode (
        .instr_i  (instr_i),
        .op_o     (op),
        .offset_o (offset),
        .bit_o    (bit_idx),
        .acc_o    (acc),
        .faddr_o  (faddr)
    );

    // quarter sequencer, four edges per instruction cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= BBSE_Q1;
        end else begin
            unique case (q)
                BBSE_Q1: q <= BBSE_Q2;
                BBSE_Q2: q <= BBSE_Q3;
                BBSE_Q3: q <= BBSE_Q4;
                BBSE_Q4: q <= BBSE_Q1;
            endcase
        end
    end

    // indexed mode selection and address formation
    assign indexed = !acc && ext_set_en_i && (faddr <= `BBSE_IDX_LIMIT);
    always_comb begin
        if (indexed) begin
            next_ea = index_ptr_i + {4'h0, faddr};
        end else if (acc) begin
            next_ea = {bank_select_register_i, faddr};
        end else begin
            // access bank: low half maps to bank 0, upper half to bank f
            next_ea = {{4{faddr[7]}}, faddr};
        end
    end

    // decode in Q1: latch class and operands; an idle cycle decodes nothing
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_op  <= BBSE_OP_NONE;
            cur_bit <= 3'h0;
            cur_ofs <= 11'sh000;
            ea      <= 12'h000;
        end else if (q == BBSE_Q1) begin
            cur_op  <= (idle || !instr_valid_i) ? BBSE_OP_NONE : op;
            cur_bit <= bit_idx;
            // the next word may already stand on instr_i by Q2, so keep the offset now
            cur_ofs <= offset;
            ea      <= next_ea;
        end
    end

    // Q2 literal capture for branch
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lit <= 11'sh000;
        end else if (q == BBSE_Q2 && cur_op == BBSE_OP_BRANCH) begin
            lit <= cur_ofs;
        end
    end

    // Q3 processing: target address and modified byte
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            target   <= CNT_W'(0);
            mod_data <= 8'h00;
        end else if (q == BBSE_Q3) begin
            // counter already incremented past this word
            target   <= program_counter_o + CNT_W'($signed({lit, 1'b0}));
            mod_data <= file_rdata_i | (8'h01 << cur_bit);
        end
    end

    // program counter: increment each cycle, branch write in Q4
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            program_counter_o <= CNT_W'(`BBSE_CNT_RST);
        end else if (q == BBSE_Q4) begin
            if (cur_op == BBSE_OP_BRANCH) begin
                program_counter_o <= target;
            end else begin
                program_counter_o <= program_counter_o + CNT_W'(2);
            end
        end
    end

    // idle marker for the second branch cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle <= 1'b0;
        end else if (q == BBSE_Q4) begin
            idle <= (cur_op == BBSE_OP_BRANCH);
        end
    end

    // register file strobes and data (Q2 read, Q4 write)
    assign file_addr_o  = ea;
    assign file_rd_o    = (q == BBSE_Q2) && (cur_op == BBSE_OP_BITSET);
    assign file_we_o    = (q == BBSE_Q4) && (cur_op == BBSE_OP_BITSET);
    assign file_wdata_o = mod_data;
    assign flush_o      = (q == BBSE_Q4) && (cur_op == BBSE_OP_BRANCH);
    assign idle_o       = idle;
    assign q_o          = q;

    // assertions, one per guarded behaviour

    // a branch loads its computed target at its Q4 edge
    AST_CNT_BRANCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q == BBSE_Q4 && cur_op == BBSE_OP_BRANCH) |=> program_counter_o == $past(target))
        else $error("branch did not load target");

    // the cycle after a branch is idle and executes nothing
    AST_REL_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q == BBSE_Q4 && cur_op == BBSE_OP_BRANCH) |=> idle ##1 cur_op == BBSE_OP_NONE)
        else $error("branch not followed by idle cycle");

    // the idle cycle lasts exactly one instruction cycle
    AST_IDLE_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q == BBSE_Q4 && idle) |=> !idle)
        else $error("idle cycle longer than one cycle");

    // the discard pulse only comes in Q4
    AST_REL_Q4: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        flush_o |-> q == BBSE_Q4)
        else $error("branch write outside Q4");

    // the counter only moves on a Q4 edge
    AST_CNT_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q != BBSE_Q4) |=> $stable(program_counter_o))
        else $error("counter moved outside Q4");

    // a word offered during the idle cycle is dropped
    AST_NO_SET_IN_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q == BBSE_Q1 && idle) |=> cur_op == BBSE_OP_NONE)
        else $error("prefetched word executed after branch");

    // no file strobe and no branch flush during the idle cycle; the counter still steps by two
    AST_IDLE_QUIET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        idle |-> (!file_rd_o && !file_we_o && !flush_o))
        else $error("activity during idle cycle");

    // read in Q2 is followed by the write in Q4
    AST_SET_SEQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        file_rd_o |=> ##1 file_we_o)
        else $error("bit-set write not two quarters after read");

    // the file address stands for the whole cycle
    AST_SET_ADDR_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q != BBSE_Q1) |=> $stable(file_addr_o))
        else $error("file address moved inside a cycle");

    // written byte is the read byte with the chosen bit forced high
    AST_SET_BIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        file_we_o |-> (file_wdata_o[cur_bit] && ((file_wdata_o | (8'h01 << cur_bit))
                      == ($past(file_rdata_i, 1) | (8'h01 << cur_bit)))))
        else $error("bit-set data wrong");

    // indexed literal offset address is pointer plus field
    AST_IDX_ADDR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q == BBSE_Q1 && indexed) |=> ea == $past(index_ptr_i) + {4'h0, $past(faddr)})
        else $error("indexed address wrong");

    // access flag set: bank comes from the bank select input
    AST_BANK_ADDR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q == BBSE_Q1 && acc) |=> ea[11:8] == $past(bank_select_register_i))
        else $error("bank select not applied");

    // access flag clear, not indexed: bank 0 or bank f by the top address bit
    AST_ACC_ADDR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q == BBSE_Q1 && !acc && !indexed) |=> ea[11:8] == {4{ea[7]}} && ea[7:0] == $past(faddr))
        else $error("access bank address wrong");

    // a bit-set steps the counter by one word
    AST_SET_CNT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q == BBSE_Q4 && cur_op == BBSE_OP_BITSET) |=> program_counter_o == $past(program_counter_o) + CNT_W'(2))
        else $error("bit-set disturbed counter");
endmodule // bbse_core
`default_nettype wire

// >>> verification/tb_bbse_core.sv
`timescale 1ns/100ps
`default_nettype none
// compare one value and count the outcome
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("unexpected %s: expected %0h seen %0h", nm, (ex), (got)); end end
module tb_bbse_core;
    import bbse_pkg::*;
    localparam int PW = 21;              // program counter width under test
    logic            clk_i = 1'b0;       // core clock, 8 ns
    logic            rst_n_i = 1'b0;     // reset, active low
    logic [15:0]     instr_i = 16'h0000; // instruction word
    logic            instr_valid_i = 1'b0; // word present
    logic [3:0]      bank_sel = 4'h0;    // bank select
    logic            ext = 1'b0;         // extended set enable
    logic [11:0]     ptr = 12'h000;      // index pointer
    logic [7:0]      file_rdata_i = 8'h00; // register file answer
    logic [PW-1:0]   prog_cnt;           // program counter seen
    logic [11:0]     faddr;              // file address seen
    logic            rd, we, flush, idle; // strobes seen
    logic [7:0]      wdata;              // write data seen
    bbse_q_e         q;                  // quarter seen
    int              num_errors = 0;     // mismatches
    int              n_checks = 0;       // comparisons
    logic [7:0]      f_tab [8] = '{8'h00, 8'h5f, 8'h60, 8'h7f, 8'h80, 8'hff, 8'h5e, 8'h10}; // file addresses

    bbse_core #(.CNT_W(PW)) i_bbse_core (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
        .bank_select_register_i(bank_sel), .ext_set_en_i(ext), .index_ptr_i(ptr), .file_rdata_i(file_rdata_i),
        .program_counter_o(prog_cnt), .file_addr_o(faddr), .file_rd_o(rd), .file_we_o(we),
        .file_wdata_o(wdata), .flush_o(flush), .idle_o(idle), .q_o(q));

    // clock generator
    always #4 clk_i = ~clk_i;

    // one quarter, inputs settle 1 ns after the edge
    task automatic step;
        @(posedge clk_i);
        #1;
    endtask

    // wait until the next edge takes a new instruction
    task automatic to_q1;
        int k;
        k = 0;
        while (q !== BBSE_Q1 && k < 8) begin
            step;
            k++;
        end
    endtask

    // hold reset for 12 cycles and check the idle state
    task automatic do_reset;
        rst_n_i = 1'b0;
        repeat (12) step;
        `CHK("cnt_rst", {PW{1'b0}}, prog_cnt)
        `CHK("q_rst", BBSE_Q1, q)
        `CHK("idle_rst", 1'b0, idle)
        rst_n_i = 1'b1;
    endtask

    // bit-set: address, read in Q2, write in Q4, counter plus two
    task automatic bitset(input logic [2:0] b, input logic a, input logic [7:0] f, input logic [3:0] s,
                          input logic x, input logic [11:0] p, input logic [7:0] r);
        logic [11:0]   ea;
        logic [PW-1:0] cnt0;
        to_q1;
        if (a) ea = {s, f};
        else if (x && f <= 8'h5f) ea = p + {4'h0, f};
        else ea = (f < 8'h80) ? {4'h0, f} : {4'hf, f};
        cnt0 = prog_cnt;
        instr_i = {4'h8, b, a, f};
        bank_sel = s; ext = x; ptr = p; file_rdata_i = r; instr_valid_i = 1'b1;
        step;
        `CHK("file_rd", 1'b1, rd)
        `CHK("file_addr", ea, faddr)
        instr_valid_i = 1'b0;
        step;
        step;
        `CHK("file_we", 1'b1, we)
        `CHK("file_wdata", r | (8'h01 << b), wdata)
        step;
        `CHK("cnt_bitset", cnt0 + 21'd2, prog_cnt)
    endtask

    // branch: target, flush in Q4, idle cycle ignores the prefetched word
    task automatic branch(input logic [10:0] n);
        logic [PW-1:0] tgt;
        to_q1;
        tgt = prog_cnt + {{(PW-12){n[10]}}, n, 1'b0};
        instr_i = {5'h1a, n};
        instr_valid_i = 1'b1;
        step;
        instr_i = 16'h8e05;
        step;
        step;
        `CHK("flush", 1'b1, flush)
        `CHK("we_branch", 1'b0, we)
        step;
        `CHK("cnt_branch", tgt, prog_cnt)
        `CHK("idle_on", 1'b1, idle)
        step;
        `CHK("rd_idle", 1'b0, rd)
        instr_valid_i = 1'b0;
        step;
        step;
        step;
        `CHK("idle_off", 1'b0, idle)
    endtask

    // foreign opcode or absent word: no file access, no flush, counter plus two
    task automatic other(input logic [15:0] w, input logic v);
        logic [PW-1:0] cnt0;
        to_q1;
        cnt0 = prog_cnt;
        instr_i = w;
        instr_valid_i = v;
        step;
        `CHK("rd_other", 1'b0, rd)
        instr_valid_i = 1'b0;
        step;
        step;
        `CHK("we_other", 1'b0, we)
        `CHK("flush_other", 1'b0, flush)
        step;
        `CHK("cnt_other", cnt0 + 21'd2, prog_cnt)
    endtask

    // verdict and end of run
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        do_reset;
        for (int i = 0; i < 8; i++) begin
            bitset(i[2:0], i[0], f_tab[i], 4'(i + 3), 1'b1, 12'h1f0, 8'h5a ^ 8'(i));
        end
        bitset(3'd7, 1'b0, 8'h20, 4'h2, 1'b0, 12'h300, 8'h0a);
        branch(11'h400);
        branch(11'h3ff);
        branch(11'h7ff);
        other(16'hd800, 1'b1);
        other(16'h9123, 1'b1);
        other(16'h0000, 1'b1);
        other(16'h8123, 1'b0);
        to_q1;
        instr_i = 16'h8f11;
        instr_valid_i = 1'b1;
        step;
        instr_valid_i = 1'b0;
        do_reset;
        bitset(3'd0, 1'b1, 8'h01, 4'hf, 1'b0, 12'h000, 8'hfe);
        conclude;
    end

    // watchdog against a hang
    initial begin
        #(8 * 4000);
        num_errors++;
        conclude;
    end
endmodule // tb_bbse_core
`default_nettype wire
